// [boot_pkg.sv]
// Package for the reset and boot sequencer: constants, states and carriers
package boot_pkg;

	// ------------------------------------------------------------
	// Boot copy geometry
	// ------------------------------------------------------------
	localparam int unsigned BOOT_IMAGE_BYTES = 1024; // Image size copied at boot
	localparam int unsigned WORD_BYTES = 4; // Bytes per instruction word
	localparam int unsigned BOOT_IMAGE_WORDS = BOOT_IMAGE_BYTES / WORD_BYTES;
	localparam logic [31:0] BOOT_DEST_ADDR = 32'h0000_0000; // Copy target and first fetch
	localparam logic [31:0] BOOT_ROM_BASE = 32'h9000_0000; // Start of boot ROM region
	localparam int unsigned ADDR_W = 32; // Address width
	localparam int unsigned DATA_W = 32; // Word width

	// ------------------------------------------------------------
	// Boot mode and ROM width encodings
	// ------------------------------------------------------------
	localparam logic [1:0] MODE_EMULATION = 2'h0; // Debugger releases the core
	localparam logic [1:0] MODE_ROM8 = 2'h1; // Copy from 8-bit ROM
	localparam logic [1:0] MODE_ROM16 = 2'h2; // Copy from 16-bit ROM
	localparam logic [1:0] MODE_ROM32 = 2'h3; // Copy from 32-bit ROM

	// ------------------------------------------------------------
	// Sequencer states
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		st_reset,
		st_emu_wait,
		st_copy,
		st_drain,
		st_run
	} seq_state_type;

	// ------------------------------------------------------------
	// Carriers
	// ------------------------------------------------------------
	typedef struct packed {
		logic [ADDR_W-1:0] addr; // Destination byte address
		logic [DATA_W-1:0] data; // Assembled instruction word
	} mem_write_type;

	typedef struct packed {
		logic [ADDR_W-1:0] addr; // ROM byte address of this beat
		logic [1:0] width; // ROM width code of this beat
	} rom_read_type;

endpackage : boot_pkg

// [boot_rom_model.sv]
// Boot ROM and destination memory model facing the sequencer
`timescale 1ns/1ns
`default_nettype none
module boot_rom_model
	import boot_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic slow,
	input wire logic clk_en,
	input wire rom_read_type rom_req,
	input wire logic rom_req_valid,
	output logic rom_req_ready,
	output logic [DATA_W-1:0] rom_rdata,
	output logic rom_rdata_valid,
	output logic mem_wr_ready
);
	logic tog; // Alternating stall when slow
	logic [7:0] a; // Low byte of beat address
	logic [31:0] w; // Word in system byte order
	assign a = rom_req.addr[7:0];
	assign w = {a + 8'h14, a + 8'h13, a + 8'h12, a + 8'h11};
	assign rom_req_ready = !slow || tog;
	assign mem_wr_ready = !slow || !tog;
	// Data returns one cycle after acceptance
	always @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			tog <= 1'b0;
			rom_rdata_valid <= 1'b0;
			rom_rdata <= 32'h0;
		end
		// Frozen together with the sequencer while the clock enable is low
		else if (clk_en)
		begin
			tog <= !tog;
			rom_rdata_valid <= rom_req_valid && rom_req_ready;
			// Idle bus toggles and unused lanes carry inverted bytes, never stale
			if (!(rom_req_valid && rom_req_ready))
				rom_rdata <= ~rom_rdata;
			else if (rom_req.width == MODE_ROM8)
				rom_rdata <= {~w[31:8], w[7:0]};
			else if (rom_req.width == MODE_ROM16)
				rom_rdata <= {~w[31:16], w[15:0]};
			else
				rom_rdata <= w;
		end
	end
endmodule : boot_rom_model
`default_nettype wire

// [boot_seq_checker.sv]
// Checker for the reset and boot sequencer ports
`timescale 1ns/1ns
`default_nettype none
module boot_seq_checker
	import boot_pkg::*;
#(
	parameter int unsigned IMAGE_WORDS = BOOT_IMAGE_WORDS
)
(
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic clk_en,
	input wire logic [1:0] boot_mode_select,
	input wire logic debug_release,
	input wire logic core_reset_n,
	input wire logic core_stall,
	input wire logic [ADDR_W-1:0] core_start_addr,
	input wire logic boot_busy,
	input wire rom_read_type rom_req,
	input wire logic rom_req_valid,
	input wire logic rom_req_ready,
	input wire logic [DATA_W-1:0] rom_rdata,
	input wire logic rom_rdata_valid,
	input wire mem_write_type mem_wr,
	input wire logic mem_wr_valid,
	input wire logic mem_wr_ready
);
	// One domain, so one clock for all and one default disable, which rst_hold_a overrides
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rst_n);

	rst_hold_a: assert property (disable iff (1'b0) !rst_n |->
		!core_reset_n && core_stall && !boot_busy && !rom_req_valid && !mem_wr_valid)
		else $error("reset state not held");
	start_zero_a: assert property (core_start_addr == BOOT_DEST_ADDR)
		else $error("start address not zero");
	stall_done_a: assert property (!core_stall |-> !boot_busy && !mem_wr_valid && !rom_req_valid)
		else $error("core released during copy");
	stall_keep_a: assert property (!core_stall |=> !core_stall)
		else $error("core stalled again");
	emu_hold_a: assert property (core_reset_n && core_stall && !boot_busy && !debug_release |=> core_stall)
		else $error("emulation core left stall");
	emu_go_a: assert property (core_reset_n && core_stall && !boot_busy && debug_release && clk_en |=> !core_stall)
		else $error("debug release ignored");
	req_hold_a: assert property (rom_req_valid && !rom_req_ready |=> rom_req_valid && $stable(rom_req))
		else $error("rom request dropped");
	wr_hold_a: assert property (mem_wr_valid && !mem_wr_ready |=> mem_wr_valid && $stable(mem_wr))
		else $error("memory write dropped");
	dest_range_a: assert property (mem_wr_valid |-> mem_wr.addr < 4 * IMAGE_WORDS && mem_wr.addr[1:0] == 2'h0)
		else $error("write outside image");
	rom_mode_a: assert property (rom_req_valid |-> boot_busy && rom_req.width != MODE_EMULATION)
		else $error("rom read in wrong mode");
	width_keep_a: assert property (boot_busy ##1 boot_busy |-> $stable(rom_req.width))
		else $error("rom width changed");

	cover property ($fell(core_stall));
	cover property (rom_req_valid && !rom_req_ready);
	cover property (mem_wr_valid && !mem_wr_ready);
endmodule : boot_seq_checker
bind reset_boot_sequencer boot_seq_checker #(.IMAGE_WORDS(IMAGE_WORDS)) checker_i (.sys_clk(sys_clk),
	.rst_n(rst_n), .clk_en(clk_en), .boot_mode_select(boot_mode_select), .debug_release(debug_release),
	.core_reset_n(core_reset_n), .core_stall(core_stall), .core_start_addr(core_start_addr),
	.boot_busy(boot_busy), .rom_req(rom_req), .rom_req_valid(rom_req_valid), .rom_req_ready(rom_req_ready),
	.rom_rdata(rom_rdata), .rom_rdata_valid(rom_rdata_valid), .mem_wr(mem_wr), .mem_wr_valid(mem_wr_valid),
	.mem_wr_ready(mem_wr_ready));
`default_nettype wire

// [reset_boot_sequencer.sv]
// Reset and boot sequencer: holds the core stalled and copies the boot image
`timescale 1ns/1ns
`default_nettype none
// ------------------------------------------------------------
// Notes on behaviour
// RL1: Reset low holds everything in initial state
// RL2: Reset release starts chosen boot mode
// RL3: Emulation boot stalls until debugger releases
// RL4: Debugger sets breakpoint at zero first
// RL5: ROM boot copies 1 KB to zero
// RL6: Copy is one single-frame block transfer
// RL7: Narrow ROM reads packed into 32-bit words
// RL8: Core stalled until copy completes
// RL9: ROM image stored in system byte order
// RL10: Board holds reset low through power-up
// RL11: Clock must run before reset release
// RL12: Boot mode sampled during reset, then held; code samples it at the first enabled clock edge after rst_n rises
// ------------------------------------------------------------
module reset_boot_sequencer
	import boot_pkg::*;
#(
	parameter int unsigned IMAGE_WORDS = BOOT_IMAGE_WORDS
)
(
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic clk_en,
	input wire logic [1:0] boot_mode_select,
	input wire logic debug_release,
	output logic core_reset_n,
	output logic core_stall,
	output logic [ADDR_W-1:0] core_start_addr,
	output logic boot_busy,
	output var rom_read_type rom_req,
	output logic rom_req_valid,
	input wire logic rom_req_ready,
	input wire logic [DATA_W-1:0] rom_rdata,
	input wire logic rom_rdata_valid,
	output var mem_write_type mem_wr,
	output logic mem_wr_valid,
	input wire logic mem_wr_ready
);

	localparam int unsigned CNT_W = $clog2(IMAGE_WORDS + 1);
	// Refuse image sizes the counters cannot cover
	if (IMAGE_WORDS < 1 || IMAGE_WORDS > 65536)
	begin : g_check
		$error("IMAGE_WORDS out of range");
	end

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	// Beats of the ROM per 32-bit word for a width code
	function automatic logic [2:0] beats_per_word(input logic [1:0] mode);
		case (mode)
			MODE_ROM8: beats_per_word = 3'h4;
			MODE_ROM16: beats_per_word = 3'h2;
			default: beats_per_word = 3'h1;
		endcase
	endfunction : beats_per_word

	// Byte step of the ROM address per beat
	function automatic logic [ADDR_W-1:0] beat_bytes(input logic [1:0] mode);
		beat_bytes = {{(ADDR_W-3){1'b0}}, 3'h4 / beats_per_word(mode)};
	endfunction : beat_bytes

	// ------------------------------------------------------------
	// Sequencer state
	// ------------------------------------------------------------
	seq_state_type state; // Current phase
	seq_state_type next_state;
	logic [1:0] mode; // Latched boot mode
	logic [1:0] next_mode;
	logic [ADDR_W-1:0] rd_addr; // Next ROM beat address
	logic [ADDR_W-1:0] next_rd_addr;
	logic [CNT_W-1:0] words_issued; // Words whose reads are all issued
	logic [CNT_W-1:0] next_words_issued;
	logic [2:0] beats_issued; // Beats issued within current word
	logic [2:0] next_beats_issued;

	// Buffer hand-off, driven by the packer and the buffer below
	logic buf_in_valid; // Assembled word offered to buffer
	logic buf_in_ready; // Buffer has a free slot
	logic [CNT_W-1:0] words_written; // Words accepted by the memory
	logic [CNT_W-1:0] next_words_written;
	logic [CNT_W-1:0] words_buffered; // Words pushed so far
	logic [CNT_W-1:0] next_words_buffered;

	// Next-state logic of the sequencer
	always_comb
	begin
		next_state = state;
		next_mode = mode;
		next_rd_addr = rd_addr;
		next_words_issued = words_issued;
		next_beats_issued = beats_issued;
		rom_req_valid = 1'b0;
		case (state)
			st_reset:
			begin
				// Decide from the pin: mode flop still holds its reset value here [RL2] [RL12]
				next_state = (boot_mode_select == MODE_EMULATION) ? st_emu_wait : st_copy;
			end
			st_emu_wait:
			begin
				// No code needed; wait for the debugger [RL3]
				if (debug_release)
					next_state = st_run;
			end
			st_copy:
			begin
				// New word only once packer is empty and a slot free, so requests never drop [RL5] [RL7]
				rom_req_valid = (words_issued < CNT_W'(IMAGE_WORDS)) &&
					(beats_issued != 3'h0 || (words_issued == words_buffered && buf_in_ready));
				if (rom_req_valid && rom_req_ready)
				begin
					next_rd_addr = rd_addr + beat_bytes(mode);
					if (beats_issued + 3'h1 == beats_per_word(mode))
					begin
						next_beats_issued = 3'h0;
						next_words_issued = words_issued + CNT_W'(1);
					end
					else
						next_beats_issued = beats_issued + 3'h1;
				end
				// All reads of the single frame issued [RL6]
				if (words_issued == CNT_W'(IMAGE_WORDS))
					next_state = st_drain;
			end
			st_drain:
			begin
				// Release only after the last word is written [RL8]
				if (words_written == CNT_W'(IMAGE_WORDS))
					next_state = st_run;
			end
			st_run:
				next_state = st_run;
			default:
				next_state = st_reset;
		endcase
		// Mode takes the select pin only while state is st_reset, not while rst_n is low [RL12]
		if (state == st_reset)
			next_mode = boot_mode_select;
	end

	// Registers of the sequencer; reset forces initial state [RL1]
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state <= st_reset;
			mode <= MODE_EMULATION;
			rd_addr <= BOOT_ROM_BASE;
			words_issued <= '0;
			beats_issued <= 3'h0;
		end
		else if (clk_en)
		begin
			state <= next_state;
			mode <= next_mode;
			rd_addr <= next_rd_addr;
			words_issued <= next_words_issued;
			beats_issued <= next_beats_issued;
		end
	end

	// ROM request carries address and width code
	assign rom_req = '{addr: rd_addr, width: mode};

	// ------------------------------------------------------------
	// Word packer: little-endian lanes, no byte swap
	// ------------------------------------------------------------
	logic [DATA_W-1:0] pack; // Partial word under assembly
	logic [DATA_W-1:0] next_pack;
	logic [2:0] pack_beats; // Beats gathered so far
	logic [2:0] next_pack_beats;
	logic pack_full; // Word complete, waiting for buffer
	logic next_pack_full;

	// Gather beats into lanes in arrival order [RL7]
	always_comb
	begin
		next_pack = pack;
		next_pack_beats = pack_beats;
		next_pack_full = pack_full;
		if (pack_full && buf_in_ready)
			next_pack_full = 1'b0;
		if (rom_rdata_valid && !pack_full)
		begin
			case (mode)
				MODE_ROM8: next_pack[pack_beats[1:0]*8 +: 8] = rom_rdata[7:0];
				MODE_ROM16: next_pack[pack_beats[0]*16 +: 16] = rom_rdata[15:0];
				default: next_pack = rom_rdata;
			endcase
			if (pack_beats + 3'h1 == beats_per_word(mode))
			begin
				next_pack_beats = 3'h0;
				next_pack_full = 1'b1;
			end
			else
				next_pack_beats = pack_beats + 3'h1;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pack <= '0;
			pack_beats <= 3'h0;
			pack_full <= 1'b0;
		end
		else if (clk_en)
		begin
			pack <= next_pack;
			pack_beats <= next_pack_beats;
			pack_full <= next_pack_full;
		end
	end
	assign buf_in_valid = pack_full;

	// ------------------------------------------------------------
	// Two-entry buffer toward the memory port
	// ------------------------------------------------------------
	mem_write_type slot [2]; // Buffered writes
	mem_write_type next_slot0;
	mem_write_type next_slot1;
	logic [1:0] fill; // Occupied entries
	logic [1:0] next_fill;
	logic push;
	logic pop;

	assign buf_in_ready = (fill != 2'h2);
	assign push = buf_in_valid && buf_in_ready;
	assign pop = (fill != 2'h0) && mem_wr_ready;

	// Shift-out FIFO: head always in slot 0
	always_comb
	begin
		next_slot0 = slot[0];
		next_slot1 = slot[1];
		next_fill = fill;
		next_words_buffered = words_buffered;
		next_words_written = words_written;
		if (pop)
		begin
			next_slot0 = slot[1];
			next_words_written = words_written + CNT_W'(1);
		end
		if (push)
		begin
			// Destination walks up from address zero [RL5]
			if (fill - {1'b0, pop} == 2'h0)
				next_slot0 = '{addr: BOOT_DEST_ADDR + ADDR_W'(words_buffered) * ADDR_W'(WORD_BYTES),
					data: pack};
			else
				next_slot1 = '{addr: BOOT_DEST_ADDR + ADDR_W'(words_buffered) * ADDR_W'(WORD_BYTES),
					data: pack};
			next_words_buffered = words_buffered + CNT_W'(1);
		end
		next_fill = fill + {1'b0, push} - {1'b0, pop};
	end

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			slot[0] <= '0;
			slot[1] <= '0;
			fill <= 2'h0;
			words_buffered <= '0;
			words_written <= '0;
		end
		else if (clk_en)
		begin
			slot[0] <= next_slot0;
			slot[1] <= next_slot1;
			fill <= next_fill;
			words_buffered <= next_words_buffered;
			words_written <= next_words_written;
		end
	end
	assign mem_wr = slot[0];
	assign mem_wr_valid = (fill != 2'h0);

	// ------------------------------------------------------------
	// Core control outputs
	// ------------------------------------------------------------
	// Core held in reset until sequencer leaves reset state [RL1]
	assign core_reset_n = (state != st_reset);
	// Stall until debugger release or end of copy [RL3] [RL8]
	assign core_stall = (state != st_run);
	assign boot_busy = (state == st_copy) || (state == st_drain);
	// First fetch always from address zero [RL3]
	assign core_start_addr = BOOT_DEST_ADDR;

endmodule : reset_boot_sequencer
`default_nettype wire

// [reset_boot_sequencer_test.sv]
// Testbench for the reset and boot sequencer
`timescale 1ns/1ns
`default_nettype none
module reset_boot_sequencer_test
	import boot_pkg::*;
;
	localparam int unsigned WORDS = 4; // Short image for quick runs
	logic sys_clk = 1'b0, rst_n = 1'b0, clk_en = 1'b1, debug_release = 1'b0, slow = 1'b0;
	logic [1:0] boot_mode_select = 2'h0;
	logic core_reset_n, core_stall, boot_busy, rom_req_valid, rom_req_ready, rom_rdata_valid;
	logic mem_wr_valid, mem_wr_ready;
	logic [31:0] core_start_addr, rom_rdata;
	rom_read_type rom_req;
	mem_write_type mem_wr;
	int n_errors = 0, checks_done = 0, n_wr = 0, cycles = 0;

	always #50 sys_clk = !sys_clk;

	reset_boot_sequencer #(.IMAGE_WORDS(WORDS)) dut (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en),
		.boot_mode_select(boot_mode_select), .debug_release(debug_release), .core_reset_n(core_reset_n),
		.core_stall(core_stall), .core_start_addr(core_start_addr), .boot_busy(boot_busy), .rom_req(rom_req),
		.rom_req_valid(rom_req_valid), .rom_req_ready(rom_req_ready), .rom_rdata(rom_rdata),
		.rom_rdata_valid(rom_rdata_valid), .mem_wr(mem_wr), .mem_wr_valid(mem_wr_valid), .mem_wr_ready(mem_wr_ready));
	boot_rom_model rom (.sys_clk(sys_clk), .rst_n(rst_n), .slow(slow), .clk_en(clk_en), .rom_req(rom_req),
		.rom_req_valid(rom_req_valid), .rom_req_ready(rom_req_ready), .rom_rdata(rom_rdata),
		.rom_rdata_valid(rom_rdata_valid), .mem_wr_ready(mem_wr_ready));

	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			$display("Error at %0t: got %h, expected %h", $time, got, exp);
			n_errors++;
		end
	endtask : chk

	task end_sim;
		$display("Checks %0d, errors %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : end_sim

	// Expected word i, byte k taken from ROM byte 4i+k
	function automatic logic [31:0] word(input int i);
		for (int k = 0; k < 4; k++)
			word[8*k+:8] = 8'(4 * i + k + 'h11);
	endfunction : word

	// Hang guard
	always @(posedge sys_clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			n_errors++;
			end_sim;
		end
	end

	// Every accepted write is judged in order
	always @(posedge sys_clk)
		if (rst_n && clk_en && mem_wr_valid && mem_wr_ready)
		begin
			chk(mem_wr.addr, BOOT_DEST_ADDR + 32'(4 * n_wr));
			chk(mem_wr.data, word(n_wr));
			n_wr++;
		end

	// Reset held 20 cycles with clock already running
	task boot(input logic [1:0] mode);
		@(posedge sys_clk);
		rst_n <= 1'b0;
		boot_mode_select <= mode;
		repeat (20) @(posedge sys_clk);
		n_wr = 0;
		rst_n <= 1'b1;
	endtask : boot

	task t_emu;
		boot(MODE_EMULATION);
		repeat (30) @(negedge sys_clk);
		chk(core_stall, 32'h1);
		chk(core_start_addr, BOOT_DEST_ADDR);
		chk(rom_req_valid | n_wr, 32'h0);
		@(posedge sys_clk);
		debug_release <= 1'b1; // Breakpoint at zero is in place
		@(posedge sys_clk);
		debug_release <= 1'b0;
		@(negedge sys_clk);
		chk({core_reset_n, core_stall}, 32'h2);
		$display("Emulation boot test done");
	endtask : t_emu

	task t_rom(input logic [1:0] mode, input logic s);
		slow <= s;
		boot(mode);
		@(posedge sys_clk);
		boot_mode_select <= MODE_EMULATION; // Late change must be ignored
		repeat (3) @(negedge sys_clk);
		chk({boot_busy, core_stall}, 32'h3);
		if (s)
		begin
			@(posedge sys_clk);
			clk_en <= 1'b0;
			repeat (4) @(negedge sys_clk);
			chk(boot_busy, 32'h1);
			@(posedge sys_clk);
			clk_en <= 1'b1;
		end
		for (int i = 0; i < 3000 && core_stall; i++)
			@(negedge sys_clk);
		chk(n_wr, WORDS);
		chk({core_reset_n, core_stall, boot_busy}, 32'h4);
		$display("ROM boot test mode %0d done", mode);
	endtask : t_rom

	task t_reset_mid;
		boot(MODE_ROM16);
		repeat (6) @(posedge sys_clk);
		rst_n <= 1'b0;
		@(negedge sys_clk);
		chk({core_reset_n, core_stall, boot_busy, rom_req_valid, mem_wr_valid}, 32'h8);
		$display("Reset during copy test done");
	endtask : t_reset_mid

	initial
	begin
		t_emu;
		t_rom(MODE_ROM8, 1'b0);
		t_rom(MODE_ROM8, 1'b1);
		t_rom(MODE_ROM16, 1'b1);
		t_rom(MODE_ROM32, 1'b0);
		t_reset_mid;
		t_rom(MODE_ROM32, 1'b1);
		end_sim;
	end
endmodule : reset_boot_sequencer_test
`default_nettype wire
